// ---- design/pab_pkg.sv ----
// Constants and types shared by the bus address and busy-guard front end
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package pab_pkg;

  localparam logic [6:0] PAB_BASE_RESET   = 7'h5c;
  localparam logic [6:0] PAB_GLOBAL_ADDR  = 7'h5b;
  localparam logic [6:0] PAB_ARA_ADDR     = 7'h0c;
  localparam int         PAB_BUSY_BIT     = 6;
  localparam int         PAB_SW_BUSY_BIT  = 7;

  localparam logic [7:0] PAB_CMD_CLEAR    = 8'h03;
  localparam logic [7:0] PAB_CMD_STORE    = 8'h15;
  localparam logic [7:0] PAB_CMD_RESTORE  = 8'h16;
  localparam logic [7:0] PAB_CMD_OV_LIM   = 8'h40;
  localparam logic [7:0] PAB_CMD_UV_LIM   = 8'h44;
  localparam logic [7:0] PAB_CMD_CONFIG   = 8'hd0;
  localparam logic [7:0] PAB_CMD_RAMP     = 8'h61;
  localparam logic [7:0] PAB_CMD_DAC      = 8'he0;
  localparam logic [7:0] PAB_CMD_LOG_CLR  = 8'hec;
  localparam logic [7:0] PAB_CMD_LOG_STO  = 8'hea;
  localparam logic [7:0] PAB_CMD_LOG_RES  = 8'heb;
  localparam logic [7:0] PAB_CMD_COMMON   = 8'he5;
  localparam logic [7:0] PAB_CMD_BASEADR  = 8'he3;
  localparam logic [7:0] PAB_CMD_NVM_ERS  = 8'hbd;
  localparam logic [7:0] PAB_CMD_NVM_DAT  = 8'hbf;

  localparam int CLK_MHZ           = 200;
  localparam int T_RESTORE_US      = 30000;
  localparam int T_STORE_US        = 40000;
  localparam int T_LOG_CLR_US      = 175000;
  localparam int T_LOG_STO_US      = 20000;
  localparam int T_LOG_RES_US      = 2000;
  localparam int T_NVM_US          = 20000;
  localparam int T_SHORT_US        = 49;
  localparam int T_RAM_US          = 5;
  localparam int T_CLEAR_US        = 500;

  localparam int CYC_RESTORE  = T_RESTORE_US * CLK_MHZ;
  localparam int CYC_STORE    = T_STORE_US * CLK_MHZ;
  localparam int CYC_LOG_CLR  = T_LOG_CLR_US * CLK_MHZ;
  localparam int CYC_LOG_STO  = T_LOG_STO_US * CLK_MHZ;
  localparam int CYC_LOG_RES  = T_LOG_RES_US * CLK_MHZ;
  localparam int CYC_NVM      = T_NVM_US * CLK_MHZ;
  localparam int CYC_SHORT    = T_SHORT_US * CLK_MHZ;
  localparam int CYC_RAM      = T_RAM_US * CLK_MHZ;
  localparam int CYC_CLEAR    = T_CLEAR_US * CLK_MHZ;

  typedef enum logic [1:0] {
    PAB_LVL_LOW,
    PAB_LVL_OPEN,
    PAB_LVL_HIGH
  } pab_level_type;

endpackage : pab_pkg

// ---- design/pab_addr_match.sv ----
// Address former and matcher for the serial slave front end
module pab_addr_match
  import pab_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Select pins as decoded levels
  input  wire logic [1:0] i_addr_select_lo_pin,
  input  wire logic [1:0] i_addr_select_hi_pin,
  // Base address and address under test
  input  wire logic [6:0] i_base_addr,
  input  wire logic [6:0] i_addr,
  // Results
  output logic            o_match_dev,
  output logic            o_match_gbl,
  output logic            o_match_ara,
  output logic [6:0]      o_dev_addr
);

  logic       sampled_q;
  logic [3:0] offset_q;

  function automatic logic [1:0] lvl(input logic [1:0] p);
    lvl = (p > 2'd2) ? 2'd2 : p;
  endfunction : lvl

  // Pins are caught once after reset release so a bouncing strap
  // cannot move the address mid-transaction
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sampled_q <= 1'b0;
      offset_q  <= 4'h0;
    end else if (!sampled_q) begin
      sampled_q <= 1'b1;
      offset_q  <= 4'(3 * lvl(i_addr_select_hi_pin))
                 + 4'(lvl(i_addr_select_lo_pin));
    end
  end

  always_comb begin
    o_dev_addr  = i_base_addr + 7'(offset_q);
    o_match_dev = sampled_q && (i_addr == o_dev_addr);
    o_match_gbl = (i_addr == PAB_GLOBAL_ADDR);
    o_match_ara = (i_addr == PAB_ARA_ADDR);
  end

endmodule : pab_addr_match

// ---- design/pab_busy_timer.sv ----
// Busy interval counter loaded with the larger of old and new count on each load request and cleared on expiry
module pab_busy_timer #(
  parameter int WIDTH = 26
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  // Load request
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_count,
  // State
  output logic                  o_busy
);

  logic [WIDTH-1:0] cnt_q;

  initial begin
    if (WIDTH < 2) $error("pab_busy_timer: WIDTH too small");
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_q <= '0;
    end else if (i_load) begin
      cnt_q <= (i_count > cnt_q) ? i_count : cnt_q;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_busy = (cnt_q != '0);

endmodule : pab_busy_timer

// ---- design/pab_front.sv ----
// Serial slave front end: address match, command gate and busy tracking
module pab_front
  import pab_pkg::*;
#(
  parameter int CYC_LOG_CLR_P = CYC_LOG_CLR,
  parameter int CYC_STORE_P   = CYC_STORE,
  parameter int CYC_RESTORE_P = CYC_RESTORE,
  parameter int CYC_LOG_STO_P = CYC_LOG_STO,
  parameter int CYC_LOG_RES_P = CYC_LOG_RES,
  parameter int CYC_NVM_P     = CYC_NVM,
  parameter int CYC_SHORT_P   = CYC_SHORT,
  parameter int CYC_RAM_P     = CYC_RAM,
  parameter int CYC_CLEAR_P   = CYC_CLEAR
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Select pins, two bits each: 0 low, 1 open, 2 high
  input  wire logic [1:0] i_addr_select_lo_pin,
  input  wire logic [1:0] i_addr_select_hi_pin,
  // Byte-level bus events from the serial engine
  input  wire logic       i_start,
  input  wire logic       i_stop,
  input  wire logic       i_addr_valid,
  input  wire logic [6:0] i_addr,
  input  wire logic       i_rw,
  input  wire logic       i_cmd_valid,
  input  wire logic [7:0] i_cmd,
  input  wire logic       i_data_valid,
  input  wire logic [7:0] i_data,
  input  wire logic       i_ram_write,
  input  wire logic       i_fault_log_internal,
  input  wire logic       i_status_clear,
  // Answers to the serial engine
  output logic            o_addr_ack,
  output logic            o_cmd_ack,
  output logic            o_cmd_accept,
  output logic [7:0]      o_common_status,
  output logic [7:0]      o_status_word_lo,
  output logic [6:0]      o_base_addr,
  output logic            o_faults_clearing,
  // Alert pin, active low
  output logic            o_alert_out_n
);

  // Timer width covers the longest default busy time at 200 MHz
  localparam int TW = 26;

  //----------------------------------------------------------------------
  // Elaboration checks
  //----------------------------------------------------------------------
  // A count past the timer width would wrap silently, and a zero count
  // would leave its command without any busy time at all
  function automatic bit cyc_ok(input int c);
    cyc_ok = (c >= 1) && (c < (1 << TW));
  endfunction : cyc_ok

  initial begin
    if (!cyc_ok(CYC_LOG_CLR_P))
      $error("pab_front: CYC_LOG_CLR_P out of range");
    if (!cyc_ok(CYC_STORE_P))
      $error("pab_front: CYC_STORE_P out of range");
    if (!cyc_ok(CYC_RESTORE_P))
      $error("pab_front: CYC_RESTORE_P out of range");
    if (!cyc_ok(CYC_LOG_STO_P))
      $error("pab_front: CYC_LOG_STO_P out of range");
    if (!cyc_ok(CYC_LOG_RES_P))
      $error("pab_front: CYC_LOG_RES_P out of range");
    if (!cyc_ok(CYC_NVM_P))
      $error("pab_front: CYC_NVM_P out of range");
    if (!cyc_ok(CYC_SHORT_P))
      $error("pab_front: CYC_SHORT_P out of range");
    if (!cyc_ok(CYC_RAM_P))
      $error("pab_front: CYC_RAM_P out of range");
    if (!cyc_ok(CYC_CLEAR_P))
      $error("pab_front: CYC_CLEAR_P out of range");
  end

  //----------------------------------------------------------------------
  // Address match
  //----------------------------------------------------------------------
  logic       match_dev;
  logic       match_gbl;
  logic       match_ara;
  logic [6:0] base_q;

  pab_addr_match u_match (
    .i_clk                (i_clk),
    .i_resetn             (i_resetn),
    .i_addr_select_lo_pin (i_addr_select_lo_pin),
    .i_addr_select_hi_pin (i_addr_select_hi_pin),
    .i_base_addr          (base_q),
    .i_addr               (i_addr),
    .o_match_dev          (match_dev),
    .o_match_gbl          (match_gbl),
    .o_match_ara          (match_ara),
    .o_dev_addr           ()
  );

  //----------------------------------------------------------------------
  // Transaction tracking
  //----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PAB_IDLE,
    PAB_ADDR,
    PAB_CMD,
    PAB_DROP
  } pab_state_type;

  pab_state_type state_q;
  logic          addr_hit;
  logic          cmd_fire;
  logic [7:0]    cmd_q;
  logic          cmd_taken_q;
  logic [TW-1:0] pend_cyc_q;
  logic          pend_q;
  logic          busy;
  logic          refuse;
  logic          base_wr;

  function automatic logic [TW-1:0] cmd_cycles(input logic [7:0] c);
    case (c)
      PAB_CMD_STORE:   cmd_cycles = TW'(CYC_STORE_P);
      PAB_CMD_RESTORE: cmd_cycles = TW'(CYC_RESTORE_P);
      PAB_CMD_LOG_CLR: cmd_cycles = TW'(CYC_LOG_CLR_P);
      PAB_CMD_LOG_STO: cmd_cycles = TW'(CYC_LOG_STO_P);
      PAB_CMD_LOG_RES: cmd_cycles = TW'(CYC_LOG_RES_P);
      PAB_CMD_NVM_ERS,
      PAB_CMD_NVM_DAT: cmd_cycles = TW'(CYC_NVM_P);
      PAB_CMD_CONFIG,
      PAB_CMD_RAMP,
      PAB_CMD_OV_LIM,
      PAB_CMD_UV_LIM,
      PAB_CMD_DAC:     cmd_cycles = TW'(CYC_SHORT_P);
      default:         cmd_cycles = '0;
    endcase
  endfunction : cmd_cycles

  // Status reads must pass even when busy so the host can poll
  assign refuse = busy && i_cmd_valid && (i_cmd != PAB_CMD_COMMON);

  // Any of the three addresses earns an address ack, but only the device
  // and global addresses go on to take a command
  assign addr_hit = match_dev | match_gbl | match_ara;
  assign cmd_fire = (state_q == PAB_CMD) && i_cmd_valid && !refuse;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_q <= PAB_IDLE;
    end else if (i_start) begin
      state_q <= PAB_ADDR;
    end else if (i_stop) begin
      state_q <= PAB_IDLE;
    end else begin
      case (state_q)
        // An alert response read has no command byte to take
        PAB_ADDR: if (i_addr_valid) begin
          state_q <= (match_dev | match_gbl) ? PAB_CMD : PAB_DROP;
        end
        PAB_CMD: if (i_cmd_valid) begin
          state_q <= refuse ? PAB_DROP : PAB_IDLE;
        end
        PAB_IDLE, PAB_DROP: state_q <= state_q;
        default: state_q <= PAB_IDLE;
      endcase
    end
  end

  //----------------------------------------------------------------------
  // Command acknowledge
  //----------------------------------------------------------------------
  // Address byte is acked even while busy; only the command is refused
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_addr_ack   <= 1'b0;
      o_cmd_ack    <= 1'b0;
      o_cmd_accept <= 1'b0;
    end else begin
      o_addr_ack   <= (state_q == PAB_ADDR) && i_addr_valid
                      && addr_hit;
      o_cmd_ack    <= cmd_fire;
      o_cmd_accept <= cmd_fire;
    end
  end

  //----------------------------------------------------------------------
  // Busy arming
  //----------------------------------------------------------------------
  // The command's busy time is armed at stop, not at the command byte
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cmd_q       <= 8'h00;
      cmd_taken_q <= 1'b0;
      pend_q      <= 1'b0;
      pend_cyc_q  <= '0;
    end else begin
      if (i_start) begin
        cmd_taken_q <= 1'b0;
      end else if (cmd_fire) begin
        cmd_q       <= i_cmd;
        cmd_taken_q <= !i_rw;
      end
      if (i_stop && cmd_taken_q) begin
        pend_q     <= 1'b1;
        pend_cyc_q <= cmd_cycles(cmd_q);
      end else if (i_ram_write && cmd_taken_q) begin
        pend_q     <= 1'b1;
        pend_cyc_q <= TW'(CYC_RAM_P);
      end else if (i_fault_log_internal) begin
        pend_q     <= 1'b1;
        pend_cyc_q <= TW'(CYC_LOG_STO_P);
      end else begin
        pend_q <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------------
  // Busy timer
  //----------------------------------------------------------------------
  // Loads keep the larger of old and new count, so a short write during a
  // long store cannot cut the store's busy time short
  pab_busy_timer #(
    .WIDTH (TW)
  ) u_busy (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_load   (pend_q && pend_cyc_q != '0),
    .i_count  (pend_cyc_q),
    .o_busy   (busy)
  );

  //----------------------------------------------------------------------
  // Base address setting
  //----------------------------------------------------------------------
  assign base_wr = (state_q == PAB_IDLE) && i_data_valid && cmd_taken_q
                   && (cmd_q == PAB_CMD_BASEADR);

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      base_q <= PAB_BASE_RESET;
    end else if (base_wr) begin
      base_q <= i_data[6:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_base_addr <= PAB_BASE_RESET;
    end else begin
      o_base_addr <= base_wr ? i_data[6:0] : base_q;
    end
  end

  //----------------------------------------------------------------------
  // Busy fault, alert and status
  //----------------------------------------------------------------------
  logic          clear_cmd;
  logic [TW-1:0] clr_cnt_q;

  assign clear_cmd = i_stop && cmd_taken_q && (cmd_q == PAB_CMD_CLEAR);

  // A refusal in the clearing cycle wins so no busy fault is lost
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_alert_out_n    <= 1'b1;
      o_status_word_lo <= 8'h00;
    end else if (refuse && state_q == PAB_CMD) begin
      o_alert_out_n                     <= 1'b0;
      o_status_word_lo[PAB_SW_BUSY_BIT] <= 1'b1;
    end else if (i_status_clear || (clr_cnt_q == TW'(1))) begin
      o_alert_out_n                     <= 1'b1;
      o_status_word_lo[PAB_SW_BUSY_BIT] <= 1'b0;
    end
  end

  // Clear-faults leaves busy alone; flags drop after the settle time
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      clr_cnt_q         <= '0;
      o_faults_clearing <= 1'b0;
    end else if (clear_cmd) begin
      clr_cnt_q         <= TW'(CYC_CLEAR_P);
      o_faults_clearing <= 1'b1;
    end else if (clr_cnt_q != '0) begin
      clr_cnt_q         <= clr_cnt_q - 1'b1;
      o_faults_clearing <= (clr_cnt_q != TW'(1));
    end
  end

  //----------------------------------------------------------------------
  // Common status
  //----------------------------------------------------------------------
  // Only the ready bit carries news; the spare bits read as zero
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_common_status <= 8'h00;
    end else begin
      o_common_status               <= 8'h00;
      o_common_status[PAB_BUSY_BIT] <= !busy;
    end
  end

endmodule : pab_front

// ---- test/pab_front_assertions.sv ----
// Port-level checks for the address match and busy guard front end
module pab_front_assertions
  import pab_pkg::*;
(
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_resetn,
  // Bus events
  input wire logic       i_addr_valid,
  input wire logic       i_cmd_valid,
  input wire logic [7:0] i_cmd,
  // Answers
  input wire logic       o_addr_ack,
  input wire logic       o_cmd_ack,
  input wire logic       o_cmd_accept,
  input wire logic [7:0] o_common_status,
  input wire logic [7:0] o_status_word_lo,
  input wire logic [6:0] o_base_addr,
  input wire logic       o_alert_out_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // --------------------------------------------------------------
  // Busy refusal
  // --------------------------------------------------------------
  // Status must show busy on both sides of the command, as it lags a cycle
  sequence s_busy_cmd;
    i_cmd_valid && o_addr_ack && i_cmd != PAB_CMD_COMMON &&
    !o_common_status[PAB_BUSY_BIT] ##1 !o_common_status[PAB_BUSY_BIT];
  endsequence

  a_busy_nack: assert property (s_busy_cmd |-> !o_cmd_ack)
    else $error("command acked while busy");
  a_busy_alert: assert property (s_busy_cmd |-> ##[0:1] !o_alert_out_n)
    else $error("alert not driven on busy fault");
  a_busy_word: assert property (s_busy_cmd |->
    ##[0:1] o_status_word_lo[PAB_SW_BUSY_BIT])
    else $error("status word busy bit not set");
  a_accept_ready: assert property (o_cmd_accept |-> o_cmd_ack &&
    (o_common_status[PAB_BUSY_BIT] || $past(i_cmd) == PAB_CMD_COMMON))
    else $error("command accepted while busy");

  // --------------------------------------------------------------
  // Acceptance
  // --------------------------------------------------------------
  a_common_ack: assert property (i_cmd_valid && o_addr_ack &&
    i_cmd == PAB_CMD_COMMON |=> o_cmd_ack)
    else $error("common status command refused");
  a_common_quiet: assert property (i_cmd_valid &&
    i_cmd == PAB_CMD_COMMON && o_alert_out_n |=> o_alert_out_n [*2])
    else $error("common status read raised alert");
  a_ready_accept: assert property (i_cmd_valid && o_addr_ack &&
    o_common_status[PAB_BUSY_BIT] ##1 o_common_status[PAB_BUSY_BIT]
    |-> o_cmd_ack)
    else $error("command refused while ready");
  a_clear_nobusy: assert property (i_cmd_valid && o_addr_ack &&
    i_cmd == PAB_CMD_CLEAR && o_common_status[PAB_BUSY_BIT]
    |=> o_common_status[PAB_BUSY_BIT] [*6])
    else $error("clear faults entered busy");
  a_cmd_cause: assert property (o_cmd_ack |-> $past(i_cmd_valid))
    else $error("command ack without command");
  a_addr_cause: assert property (o_addr_ack |-> $past(i_addr_valid))
    else $error("address ack without address");
  a_status_bits: assert property (o_common_status[5:0] == 6'h00 &&
    o_common_status[7] == 1'b0)
    else $error("common status spare bits set");
  a_reset_vals: assert property (disable iff (1'b0) !i_resetn |=>
    o_alert_out_n && o_base_addr == 7'h5c)
    else $error("reset values wrong");

  c_busy_fault: cover property (s_busy_cmd);
  c_clear: cover property (i_cmd_valid && i_cmd == PAB_CMD_CLEAR);
  c_busy_start: cover property ($fell(o_common_status[PAB_BUSY_BIT]));
endmodule : pab_front_assertions

// ---- test/pab_host_model.sv ----
// Host master model issuing byte-level bus events
module pab_host_model
  import pab_pkg::*;
(
  // Clock
  input  wire logic       i_clk,
  // Events towards the front end
  output logic            o_start,
  output logic            o_stop,
  output logic            o_addr_valid,
  output logic [6:0]      o_addr,
  output logic            o_rw,
  output logic            o_cmd_valid,
  output logic [7:0]      o_cmd,
  output logic            o_data_valid,
  output logic [7:0]      o_data,
  // Answers
  input  wire logic       i_addr_ack,
  input  wire logic       i_cmd_ack,
  input  wire logic [7:0] i_common_status
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {o_start, o_stop, o_addr_valid, o_rw, o_cmd_valid, o_data_valid} = '0;
    {o_addr, o_cmd, o_data} = '0;
  end

  task automatic step;
    @(posedge i_clk);
    #1;
  endtask : step

  // Released byte lines show the inverse so stale values never match
  task automatic xfer(input logic [6:0] a, input logic rw, input logic ce,
      input logic [7:0] c, input logic de, input logic [7:0] d,
      output logic aack, output logic cack);
    step(); o_start = 1'b1;
    step(); o_start = 1'b0; o_addr_valid = 1'b1; o_addr = a; o_rw = rw;
    step(); o_addr_valid = 1'b0; o_addr = ~a; aack = i_addr_ack;
    o_cmd_valid = ce; o_cmd = c;
    step(); o_cmd_valid = 1'b0; o_cmd = ~c; cack = i_cmd_ack;
    o_data_valid = de; o_data = d;
    step(); o_data_valid = 1'b0; o_data = ~d; o_stop = 1'b1;
    step(); o_stop = 1'b0; o_rw = ~rw;
  endtask : xfer

  // Poll the ready bit before the next write
  task automatic wait_ready(input int lim, output int n);
    n = 0;
    while (i_common_status[PAB_BUSY_BIT] !== 1'b1 && n < lim) begin
      step();
      n++;
    end
  endtask : wait_ready
endmodule : pab_host_model

// ---- test/pab_front_bench.sv ----
// Self-checking bench for the bus front end
module pab_front_bench
  import pab_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Short busy counts keep the run brief; all distinct to catch mixups
  localparam int P_LC = 90, P_ST = 84, P_RE = 78, P_LS = 72, P_LR = 66;
  localparam int P_NV = 60, P_SH = 54, P_RAM = 30, P_CL = 36;
  logic clk = 0, resetn = 0, ram_wr = 0, log_int = 0, st_clr = 0;
  logic [1:0] sel_lo = 0, sel_hi = 0;
  logic start, stop, av, rw, cv, dv, aack, cack, cacc, fclr, alert_n;
  logic [6:0] ad, base;
  logic [7:0] cd, dd, cst, swl;
  int fails = 0, cmp_count = 0, cyc = 0;
  logic [7:0] cmds [12] = '{PAB_CMD_RESTORE, PAB_CMD_STORE, PAB_CMD_LOG_CLR,
    PAB_CMD_LOG_STO, PAB_CMD_LOG_RES, PAB_CMD_NVM_ERS, PAB_CMD_NVM_DAT,
    PAB_CMD_CONFIG, PAB_CMD_RAMP, PAB_CMD_OV_LIM, PAB_CMD_UV_LIM,
    PAB_CMD_DAC};
  int durs [12] = '{P_RE, P_ST, P_LC, P_LS, P_LR, P_NV, P_NV, P_SH, P_SH,
    P_SH, P_SH, P_SH};
  logic [11:0] des = 12'hfc0;

  always #2.5 clk = ~clk;
  always @(posedge clk) cyc++;

  pab_front #(.CYC_LOG_CLR_P(P_LC), .CYC_STORE_P(P_ST), .CYC_RESTORE_P(P_RE),
    .CYC_LOG_STO_P(P_LS), .CYC_LOG_RES_P(P_LR), .CYC_NVM_P(P_NV),
    .CYC_SHORT_P(P_SH), .CYC_RAM_P(P_RAM), .CYC_CLEAR_P(P_CL)) u_dut (
    .i_clk(clk), .i_resetn(resetn), .i_addr_select_lo_pin(sel_lo),
    .i_addr_select_hi_pin(sel_hi), .i_start(start), .i_stop(stop),
    .i_addr_valid(av), .i_addr(ad), .i_rw(rw), .i_cmd_valid(cv),
    .i_cmd(cd), .i_data_valid(dv), .i_data(dd), .i_ram_write(ram_wr),
    .i_fault_log_internal(log_int), .i_status_clear(st_clr),
    .o_addr_ack(aack), .o_cmd_ack(cack), .o_cmd_accept(cacc),
    .o_common_status(cst), .o_status_word_lo(swl), .o_base_addr(base),
    .o_faults_clearing(fclr), .o_alert_out_n(alert_n));
  pab_host_model u_host (.i_clk(clk), .o_start(start), .o_stop(stop),
    .o_addr_valid(av), .o_addr(ad), .o_rw(rw), .o_cmd_valid(cv),
    .o_cmd(cd), .o_data_valid(dv), .o_data(dd), .i_addr_ack(aack),
    .i_cmd_ack(cack), .i_common_status(cst));

  task automatic chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic end_sim;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic do_reset;
    resetn = 0;
    step(6);
    resetn = 1;
    step(2);
  endtask : do_reset
  task automatic xf(input logic [6:0] a, input logic [7:0] c,
      input logic de, output logic aa, output logic ca);
    u_host.xfer(a, 1'b0, 1'b1, c, de, 8'h5a, aa, ca);
  endtask : xf
  task automatic ready(output int n);
    u_host.wait_ready(1000, n);
    if (n >= 1000) begin
      chk(1'b0, "wait for ready timed out");
      end_sim();
    end
  endtask : ready

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_addr;
    logic aa, ca;
    for (int h = 0; h < 3; h++) for (int l = 0; l < 3; l++) begin
      sel_hi = 2'(h); sel_lo = 2'(l);
      do_reset();
      chk(alert_n === 1'b1 && cst === 8'h40 && swl[7] === 1'b0, "idle");
      chk(base === 7'h5c, "base reset");
      sel_hi = 2'(2 - h); // pins move after sampling
      xf(7'h5c + 7'(3 * h + l), PAB_CMD_COMMON, 0, aa, ca);
      chk(aa === 1'b1 && ca === 1'b1, "device address");
      xf(7'h65, PAB_CMD_COMMON, 0, aa, ca);
      chk(aa === 1'b0, "foreign address acked");
      xf(7'h5b, PAB_CMD_COMMON, 0, aa, ca);
      chk(aa === 1'b1, "global address");
      u_host.xfer(7'h0c, 1'b1, 1'b0, 8'h00, 1'b0, 8'h00, aa, ca);
      chk(aa === 1'b1, "alert response address");
    end
    sel_hi = 0; sel_lo = 0;
    do_reset();
  endtask : t_addr
  task automatic t_base;
    logic aa, ca;
    int n;
    xf(7'h5c, PAB_CMD_BASEADR, 1, aa, ca);
    ready(n);
    chk(ca === 1'b1 && base === 7'h5a, "base write");
    xf(7'h5a, PAB_CMD_COMMON, 0, aa, ca);
    chk(aa === 1'b1, "new base");
    xf(7'h5c, PAB_CMD_COMMON, 0, aa, ca);
    chk(aa === 1'b0, "old base still acked");
    do_reset();
  endtask : t_base
  task automatic t_busy(input logic [7:0] c, input logic de, input int p);
    logic aa, ca;
    int n, t0;
    xf(7'h5c, c, de, aa, ca);
    t0 = cyc;
    chk(ca === 1'b1, "trigger refused");
    step(3);
    chk(cst[6] === 1'b0, "busy not shown");
    xf(7'h5c, PAB_CMD_RAMP, 1, aa, ca);
    chk(aa === 1'b1 && ca === 1'b0, "busy ack pattern");
    chk(alert_n === 1'b0 && swl[7] === 1'b1, "busy fault");
    xf(7'h5c, PAB_CMD_COMMON, 0, aa, ca);
    chk(ca === 1'b1, "common while busy");
    ready(n);
    chk(cyc - t0 >= p && cyc - t0 <= p + 3, "busy length");
    st_clr = 1; step(1); st_clr = 0; step(2);
    chk(alert_n === 1'b1 && swl[7] === 1'b0, "status clear");
  endtask : t_busy
  task automatic t_pulse(input bit ram, input int p);
    int n, t0;
    if (ram) ram_wr = 1; else log_int = 1;
    step(1); ram_wr = 0; log_int = 0;
    t0 = cyc;
    step(3);
    chk(cst[6] === 1'b0, "event busy");
    ready(n);
    chk(cyc - t0 >= p && cyc - t0 <= p + 3, "event length");
  endtask : t_pulse
  task automatic t_clear;
    logic aa, ca;
    int n;
    xf(7'h5c, PAB_CMD_RESTORE, 0, aa, ca);
    xf(7'h5c, PAB_CMD_DAC, 1, aa, ca);
    ready(n);
    xf(7'h5c, PAB_CMD_CLEAR, 0, aa, ca);
    chk(ca === 1'b1 && fclr === 1'b1, "clear faults");
    xf(7'h5c, PAB_CMD_RAMP, 1, aa, ca);
    chk(ca === 1'b1, "command after clear");
    n = 0;
    while (alert_n !== 1'b1 && n < P_CL + 10) begin step(1); n++; end
    chk(alert_n === 1'b1 && fclr === 1'b0, "clear faults release");
    ready(n);
  endtask : t_clear

  initial begin
    t_addr();
    t_base();
    for (int i = 0; i < 12; i++) t_busy(cmds[i], des[i], durs[i]);
    t_pulse(1'b0, P_LS);
    t_pulse(1'b1, P_RAM);
    t_clear();
    end_sim();
  end
endmodule : pab_front_bench

bind pab_front pab_front_assertions u_chk (.*);
